// ===== verilog/dcud_map.svh
// register offsets, field positions and reset values of the upset detector
`ifndef DCUD_MAP_SVH
`define DCUD_MAP_SVH

`define DCUD_ACC_W 32
`define DCUD_CLK_W 4
`define DCUD_SEL_W 2
`define DCUD_ADR_W 8
`define DCUD_DAT_W 32
`define DCUD_ALM_W 2

`define DCUD_OFF_CTRL 8'h00
`define DCUD_OFF_STATUS 8'h04
`define DCUD_OFF_MASK 8'h08
`define DCUD_OFF_INTST 8'h0C
`define DCUD_OFF_SUMMARY 8'h10

`define DCUD_CTRL_LINK_EN 0
`define DCUD_CTRL_PD_A 1
`define DCUD_CTRL_PD_B 2
`define DCUD_CTRL_GPD 3
`define DCUD_CTRL_SYNC_ILA 4
`define DCUD_CTRL_CAL_ALM 5
`define DCUD_CTRL_W 6

`define DCUD_ST_NCO 0
`define DCUD_ST_CLK 1
`define DCUD_ST_SYNCED 2
`define DCUD_ST_SEL_DIFF 3
`define DCUD_ST_CMP_EN 4
`define DCUD_ST_GPD 5

`define DCUD_RST_CTRL 6'h00
`define DCUD_RST_MASK 2'h3

`endif

// ===== verilog/dcud_pkg.sv
// types shared by the dual channel upset detector
`include "dcud_map.svh"
`default_nettype none
package dcud_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [`DCUD_ADR_W-1:0] adr;
    logic [`DCUD_DAT_W-1:0] dat;
  } dcud_wb_req_type;

  typedef struct packed {
    logic [`DCUD_ACC_W-1:0] acc_a;
    logic [`DCUD_ACC_W-1:0] acc_b;
    logic [`DCUD_CLK_W-1:0] clk_a;
    logic [`DCUD_CLK_W-1:0] clk_b;
  } dcud_mon_type;

  typedef struct packed {
    logic power_down_pin;
    logic sysref;
    logic [`DCUD_SEL_W-1:0] chan_a_freq_select_pins;
    logic [`DCUD_SEL_W-1:0] chan_b_freq_select_pins;
  } dcud_pins_type;

  typedef struct packed {
    dcud_pins_type p1;
    dcud_pins_type p2;
    dcud_pins_type p3;
    dcud_pins_type flt;
    logic [`DCUD_CTRL_W-1:0] ctrl;
    logic nco_mismatch_flag;
    logic clock_mismatch_flag;
    logic synced;
    logic half;
    logic [`DCUD_ALM_W-1:0] int_st;
    logic [`DCUD_ALM_W-1:0] mask;
    logic ack;
    logic [`DCUD_DAT_W-1:0] dat;
    logic irq;
    logic cal_status_pin;
    logic link_rst_n;
    logic ser_pd;
    logic link_clk_en;
  } dcud_state_type;

endpackage
`default_nettype wire

// ===== verilog/dcud_upset_det.sv
// dual channel nco and clock upset detector with wishbone registers
//
// Notes on behaviour
// - nco accumulators of channel a are compared with channel b while cmp_en is set.
// - one cycle of accumulator mismatch sets the nco flag; write 1 clears.
// - only same-index words must match; two hopping frequencies remain.
// - differing frequency select pins let channel b run another frequency.
// - nco results count only after sysref or ila start synchronisation.
// - internal clocks of channel a are compared with channel b while cmp_en is set.
// - one half-rate cycle of clock mismatch sets clock flag; write 1 clears.
// - leaving global power-down may set the clock flag; host clears it.
// - either unmasked flag reaches the calibration status pin in alarm mode.
// - unmasked flags show in the summary; masked ones still set status.
// - in alarm mode the status pin is high while any reported alarm set.
// - link enable low holds link in reset, serializers down, clocks off.
`include "dcud_map.svh"
`default_nettype none

module dcud_upset_det (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // wishbone slave
  input wire dcud_pkg::dcud_wb_req_type wb_req,
  output logic wb_ack_o,
  output logic [`DCUD_DAT_W-1:0] wb_dat_o,
  // channel monitors and link events, same clock
  input wire dcud_pkg::dcud_mon_type mon,
  input wire logic ila_start,
  input wire logic cal_busy,
  // device pins, asynchronous
  input wire dcud_pkg::dcud_pins_type pins,
  // outputs
  output logic irq,
  output logic cal_status_pin,
  output logic link_rst_n,
  output logic ser_pd,
  output logic link_clk_en,
  output logic [`DCUD_SEL_W-1:0] chan_a_freq_select,
  output logic [`DCUD_SEL_W-1:0] chan_b_freq_select
);

  ////////////////////////////////////////////////////////////////////////////
  // a pin bit moves only once the second and third stages agree
  function automatic dcud_pkg::dcud_pins_type pin_filter(
    input dcud_pkg::dcud_pins_type s2,
    input dcud_pkg::dcud_pins_type s3,
    input dcud_pkg::dcud_pins_type old
  );
    logic [$bits(dcud_pkg::dcud_pins_type)-1:0] agree;
    agree = ~(s2 ^ s3);
    pin_filter = (agree & s3) | (~agree & old);
  endfunction

  // write-one-to-clear with the set taking priority
  function automatic logic w1c_flag(
    input logic old,
    input logic set,
    input logic clr
  );
    w1c_flag = set | (old & ~clr);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  dcud_pkg::dcud_state_type s_r;
  dcud_pkg::dcud_state_type s_nxt;

  logic gpd;
  logic cmp_en;
  logic sel_equal;
  logic sync_ev;
  logic nco_ev;
  logic clk_ev;
  logic acc_diff;
  logic clk_diff;
  logic take;
  logic wr;
  logic rd;
  logic [`DCUD_ALM_W-1:0] flags;
  logic [`DCUD_ALM_W-1:0] ev;
  logic [`DCUD_ALM_W-1:0] clr;
  logic [`DCUD_DAT_W-1:0] rdata;

  always_comb begin
    s_nxt = s_r;
    // three-stage pin capture; stage one feeds stage two only
    s_nxt.p1 = pins;
    s_nxt.p2 = s_r.p1;
    s_nxt.p3 = s_r.p2;
    s_nxt.flt = pin_filter(s_r.p2, s_r.p3, s_r.flt);

    gpd = s_r.ctrl[`DCUD_CTRL_GPD] | s_r.flt.power_down_pin;
    // a lone powered channel would always look upset
    cmp_en = ~s_r.ctrl[`DCUD_CTRL_PD_A] & ~s_r.ctrl[`DCUD_CTRL_PD_B]
      & ~gpd & s_r.ctrl[`DCUD_CTRL_LINK_EN];
    // different selects mean deliberately different frequencies
    sel_equal = s_r.flt.chan_a_freq_select_pins
      == s_r.flt.chan_b_freq_select_pins;

    sync_ev = s_r.ctrl[`DCUD_CTRL_SYNC_ILA] ? ila_start
      : (s_r.flt.sysref & ~pin_filter(s_r.p2, s_r.p3, s_r.flt).sysref
         ? 1'b0 : (pin_filter(s_r.p2, s_r.p3, s_r.flt).sysref
         & ~s_r.flt.sysref));
    // power-down or link off loses alignment until the next sync
    if (!cmp_en) begin
      s_nxt.synced = 1'b0;
    end else if (sync_ev) begin
      s_nxt.synced = 1'b1;
    end

    acc_diff = mon.acc_a != mon.acc_b;
    nco_ev = cmp_en & s_r.synced & sel_equal & acc_diff;

    // clock comparison runs on every second device clock
    s_nxt.half = ~s_r.half;
    clk_diff = mon.clk_a != mon.clk_b;
    clk_ev = s_r.half & cmp_en & clk_diff;

    ////////////////////////////////////////////////////////////////////////
    take = wb_req.cyc & wb_req.stb & ~s_r.ack;
    wr = take & wb_req.we & wb_req.sel[0];
    rd = take & ~wb_req.we;
    s_nxt.ack = take;

    ev = {clk_ev, nco_ev};
    clr = '0;
    if (wr && wb_req.adr == `DCUD_OFF_STATUS) begin
      clr = wb_req.dat[`DCUD_ALM_W-1:0];
    end
    s_nxt.nco_mismatch_flag = w1c_flag(s_r.nco_mismatch_flag,
      ev[`DCUD_ST_NCO], clr[`DCUD_ST_NCO]);
    s_nxt.clock_mismatch_flag = w1c_flag(s_r.clock_mismatch_flag,
      ev[`DCUD_ST_CLK], clr[`DCUD_ST_CLK]);

    // interrupt copy is cleared by reading it, events still win
    if (rd && wb_req.adr == `DCUD_OFF_INTST) begin
      s_nxt.int_st = ev;
    end else begin
      s_nxt.int_st = s_r.int_st | ev;
    end

    if (wr && wb_req.adr == `DCUD_OFF_CTRL) begin
      s_nxt.ctrl = wb_req.dat[`DCUD_CTRL_W-1:0];
    end
    if (wr && wb_req.adr == `DCUD_OFF_MASK) begin
      s_nxt.mask = wb_req.dat[`DCUD_ALM_W-1:0];
    end

    flags = {s_r.clock_mismatch_flag, s_r.nco_mismatch_flag};
    rdata = '0;
    unique case (wb_req.adr)
      `DCUD_OFF_CTRL: begin
        rdata[`DCUD_CTRL_W-1:0] = s_r.ctrl;
      end
      `DCUD_OFF_STATUS: begin
        rdata[`DCUD_ALM_W-1:0] = flags;
        rdata[`DCUD_ST_SYNCED] = s_r.synced;
        rdata[`DCUD_ST_SEL_DIFF] = ~sel_equal;
        rdata[`DCUD_ST_CMP_EN] = cmp_en;
        rdata[`DCUD_ST_GPD] = gpd;
      end
      `DCUD_OFF_MASK: begin
        rdata[`DCUD_ALM_W-1:0] = s_r.mask;
      end
      `DCUD_OFF_INTST: begin
        rdata[`DCUD_ALM_W-1:0] = s_r.int_st;
      end
      `DCUD_OFF_SUMMARY: begin
        rdata[0] = |(flags & ~s_r.mask);
      end
      default: begin
        rdata = '0;
      end
    endcase
    s_nxt.dat = rd ? rdata : '0;

    ////////////////////////////////////////////////////////////////////////
    s_nxt.irq = |(s_nxt.int_st & ~s_nxt.mask);
    if (s_r.ctrl[`DCUD_CTRL_CAL_ALM]) begin
      s_nxt.cal_status_pin = |(s_nxt.nco_mismatch_flag & ~s_nxt.mask[0]
        | s_nxt.clock_mismatch_flag & ~s_nxt.mask[1]);
    end else begin
      s_nxt.cal_status_pin = cal_busy;
    end
    // link block parked while its enable is low
    s_nxt.link_rst_n = s_nxt.ctrl[`DCUD_CTRL_LINK_EN];
    s_nxt.ser_pd = ~s_nxt.ctrl[`DCUD_CTRL_LINK_EN];
    s_nxt.link_clk_en = s_nxt.ctrl[`DCUD_CTRL_LINK_EN];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.ctrl <= `DCUD_RST_CTRL;
      s_r.mask <= `DCUD_RST_MASK;
      s_r.ser_pd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;
  assign irq = s_r.irq;
  assign cal_status_pin = s_r.cal_status_pin;
  assign link_rst_n = s_r.link_rst_n;
  assign ser_pd = s_r.ser_pd;
  assign link_clk_en = s_r.link_clk_en;
  assign chan_a_freq_select = s_r.flt.chan_a_freq_select_pins;
  assign chan_b_freq_select = s_r.flt.chan_b_freq_select_pins;

endmodule // dcud_upset_det
`default_nettype wire

// ===== test/dcud_upset_det_props.sv
// assertions on the upset detector's bus and link-control ports
`include "dcud_map.svh"
`default_nettype none
module dcud_upset_det_props (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus
  input wire dcud_pkg::dcud_wb_req_type wb_req,
  input wire logic wb_ack_o,
  input wire logic [`DCUD_DAT_W-1:0] wb_dat_o,
  // outputs
  input wire logic irq,
  input wire logic cal_status_pin,
  input wire logic link_rst_n,
  input wire logic ser_pd,
  input wire logic link_clk_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic tk;
  logic ctl_wr;
  assign tk = wb_req.cyc && wb_req.stb && !wb_ack_o;
  assign ctl_wr = tk && wb_req.we && wb_req.sel[0]
    && wb_req.adr == `DCUD_OFF_CTRL;
  ////////////////////////////////////////////////////////////////////////////
  AST_ACK_TAKEN: assert property (tk |=> wb_ack_o)
    else $error("request not acked");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(tk))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside ack");
  AST_UNMAPPED: assert property (tk && wb_req.adr == 8'h14 |=> wb_dat_o == '0)
    else $error("unmapped read not zero");
  AST_LINK_ON: assert property (link_rst_n |-> link_clk_en && !ser_pd)
    else $error("link on but gated");
  AST_LINK_OFF: assert property (!link_rst_n |-> ser_pd && !link_clk_en)
    else $error("link off but running");
  AST_EN_WR1: assert property (ctl_wr && wb_req.dat[0] |-> ##[1:3] link_rst_n)
    else $error("link enable write lost");
  AST_EN_WR0: assert property (ctl_wr && !wb_req.dat[0] |-> ##[1:3] !link_rst_n)
    else $error("link disable write lost");
  cover property (tk && wb_req.we);
  cover property ($rose(irq));
  cover property ($rose(cal_status_pin));
endmodule // dcud_upset_det_props

bind dcud_upset_det dcud_upset_det_props dcud_upset_det_props_i (
  .clk(clk), .rstn(rstn), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .irq(irq), .cal_status_pin(cal_status_pin),
  .link_rst_n(link_rst_n), .ser_pd(ser_pd), .link_clk_en(link_clk_en));
`default_nettype wire

// ===== test/dcud_upset_det_tb.sv
// self-checking bench for the dual channel upset detector
`include "dcud_map.svh"
`default_nettype none
module dcud_upset_det_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, ila_start, cal_busy, ack, irq, cal, lrst, spd, lclk;
  logic [31:0] rd, rv;
  logic [1:0] sa, sb;
  dcud_pkg::dcud_wb_req_type wb;
  dcud_pkg::dcud_mon_type mon;
  dcud_pkg::dcud_pins_type pins;
  int failures, checks, cyc_n, seed;
  dcud_upset_det dcud_upset_det_i (.clk(clk), .rstn(rstn), .wb_req(wb),
    .wb_ack_o(ack), .wb_dat_o(rd), .mon(mon), .ila_start(ila_start),
    .cal_busy(cal_busy), .pins(pins), .irq(irq), .cal_status_pin(cal),
    .link_rst_n(lrst), .ser_pd(spd), .link_clk_en(lclk),
    .chan_a_freq_select(sa), .chan_b_freq_select(sb));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cy(input int k);
    repeat (k) @(posedge clk);
  endtask
  // the bus cycle waits for ack without assuming its latency
  task automatic wbx(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
    do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
    rv = rd;
    if (n == 20) begin
      failures++;
      $display("[ERR] %0t bus ack timeout", $time);
    end
    wb <= '0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wbx(1'b0, a, 32'h0000_0000);
    chk(rv, e);
  endtask
  // one cycle of accumulator disagreement
  task automatic blip();
    mon.acc_b <= mon.acc_a ^ 32'h0000_0001;
    @(posedge clk);
    mon.acc_b <= mon.acc_a;
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    rstn = 1'b0;
    wb = '0;
    mon = '0;
    pins = '0;
    ila_start = 1'b0;
    cal_busy = 1'b0;
    seed = 50482;
    cy(12);
    rstn <= 1'b1;
    cy(1);
    chk({lrst, spd, lclk}, 3'b010);
    rdc(`DCUD_OFF_CTRL, 32'h0000_0000);
    rdc(`DCUD_OFF_MASK, 32'h0000_0003);
    wbx(1'b1, 8'h14, 32'hffff_ffff);
    rdc(8'h14, 32'h0000_0000);
    mon.acc_a <= $random(seed);
    cy(1);
    blip();
    rdc(`DCUD_OFF_STATUS, 32'h0000_0000);
    wbx(1'b1, `DCUD_OFF_CTRL, 32'h0000_0001);
    cy(2);
    chk({lrst, spd, lclk}, 3'b101);
    mon.clk_b <= 4'h1;
    cy(2);
    mon.clk_b <= 4'h0;
    rdc(`DCUD_OFF_STATUS, 32'h0000_0012);
    wbx(1'b1, `DCUD_OFF_STATUS, 32'h0000_0000);
    rdc(`DCUD_OFF_STATUS, 32'h0000_0012);
    wbx(1'b1, `DCUD_OFF_STATUS, 32'h0000_0002);
    rdc(`DCUD_OFF_STATUS, 32'h0000_0010);
    blip();
    rdc(`DCUD_OFF_STATUS, 32'h0000_0010);
    pins.sysref <= 1'b1;
    cy(8);
    pins.sysref <= 1'b0;
    cy(6);
    rdc(`DCUD_OFF_STATUS, 32'h0000_0014);
    blip();
    rdc(`DCUD_OFF_STATUS, 32'h0000_0015);
    chk(irq, 1'b0);
    wbx(1'b1, `DCUD_OFF_MASK, 32'h0000_0000);
    cy(2);
    chk(irq, 1'b1);
    rdc(`DCUD_OFF_SUMMARY, 32'h0000_0001);
    rdc(`DCUD_OFF_INTST, 32'h0000_0003);
    cy(2);
    chk(irq, 1'b0);
    wbx(1'b1, `DCUD_OFF_CTRL, 32'h0000_0021);
    cy(2);
    chk(cal, 1'b1);
    wbx(1'b1, `DCUD_OFF_STATUS, 32'h0000_0001);
    cy(2);
    chk(cal, 1'b0);
    pins.chan_b_freq_select_pins <= 2'h2;
    cy(8);
    chk(sb, 2'h2);
    blip();
    rdc(`DCUD_OFF_STATUS, 32'h0000_001c);
    pins.chan_b_freq_select_pins <= 2'h0;
    cy(8);
    wbx(1'b1, `DCUD_OFF_CTRL, 32'h0000_0003);
    blip();
    mon.clk_b <= 4'h3;
    cy(2);
    mon.clk_b <= 4'h0;
    rdc(`DCUD_OFF_STATUS, 32'h0000_0000);
    wbx(1'b1, `DCUD_OFF_CTRL, 32'h0000_0011);
    ila_start <= 1'b1;
    cy(1);
    ila_start <= 1'b0;
    cy(2);
    rdc(`DCUD_OFF_STATUS, 32'h0000_0014);
    chk(sa, 2'h0);
    cal_busy <= 1'b1;
    cy(2);
    chk(cal, 1'b1);
    pins.power_down_pin <= 1'b1;
    cy(8);
    rdc(`DCUD_OFF_STATUS, 32'h0000_0020);
    pins.power_down_pin <= 1'b0;
    cy(8);
    rdc(`DCUD_OFF_STATUS, 32'h0000_0010);
    complete_run();
  end
endmodule // dcud_upset_det_tb
`default_nettype wire
